// file: design/rbl_params.svh
// Purpose: Constants of the reset boot loader
// Assumes: 100 MHz system clock, all counts in clock cycles
// Notes:   Included by the loader only
`ifndef RBL_PARAMS_SVH
`define RBL_PARAMS_SVH

// Boot mode codes
`define RBL_MODE_EXT       3'h0
`define RBL_MODE_FLASH     3'h1
`define RBL_MODE_SPI8      3'h2
`define RBL_MODE_SPI16     3'h3

// Start addresses
`define RBL_EXT_START      32'h0200_0000
`define RBL_L2_BASE        32'h0000_0000

// Flash bank 0 timing, cycles
`define RBL_FL_SETUP       5'h04
`define RBL_FL_ACCESS      5'h0F
`define RBL_FL_HOLD        5'h03

// Serial boot memory
`define RBL_SPI_READ_CMD   8'h03
`define RBL_SPI_ADDR       16'h0000
`define RBL_SPI_HALF       3'h4

// Load sequence
`define RBL_LEN_BYTES      3'h4
`define RBL_SETTLE         5'h02
`define RBL_FIFO_DEPTH     4
`define RBL_L2_AW          24

`endif

// file: design/rbl_pkg.sv
// Purpose: Types of the reset boot loader
// Assumes: Constants come from rbl_params.svh
// Notes:   States carry no codes
`default_nettype none

package rbl_pkg;

    typedef enum logic [3:0] {
        ST_SETTLE,
        ST_DISPATCH,
        ST_CMD,
        ST_SPI_BYTE,
        ST_FL_SETUP,
        ST_FL_ACCESS,
        ST_FL_HOLD,
        ST_STORE,
        ST_DRAIN,
        ST_RUN,
        ST_ERROR
    } rbl_state_e;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic [7:0]  data;
    } rbl_l2_wr_s;

endpackage

`default_nettype wire

// file: design/rbl_fifo.sv
// Purpose: Small synchronous FIFO between byte fetch and memory writes
// Assumes: Single clock, DEPTH a power of two
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none

module rbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || flush_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// file: design/rbl_loader.sv
// Purpose: Reset-time boot sequencer: run external or load second level memory
// Assumes: Boot pins, flash data and serial input are asynchronous pins
// Notes:   Count header is little-endian, four bytes
//
// Function
// - Decode boot code: 000 external, 001 flash, 010/011 serial, rest reserved.
// - Capture boot code on power-on and software resets, act on captured value.
// - External mode skips loading, starts at 0x2000000 with 16-bit packing.
// - Flash boot uses bank 0, setup 4, access 15, hold 3 cycles.
// - One-byte serial mode selects with flag ten, reads from address 0x00.
// - Two-byte serial mode selects with flag ten, reads from address 0x0000.
// - Read four-byte count first, then exactly that many bytes into memory.
// - After load completes, jump to first address of second level memory.
// - Bypass option on software reset jumps straight to second level memory.
`timescale 1ns/1ps
`default_nettype none
`include "rbl_params.svh"

module rbl_loader (
    // Clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    // Reset configuration
    input  wire logic          sw_reset_i,
    input  wire logic          bypass_boot_i,
    input  wire logic [2:0]    boot_mode_code_i,
    // Asynchronous bank 0 flash
    output logic               bank0_sel_n_o,
    output logic               flash_rd_n_o,
    output logic [23:0]        flash_addr_o,
    input  wire logic [7:0]    flash_data_i,
    // First serial peripheral port
    output logic               spi_sck_o,
    output logic               spi_mosi_o,
    input  wire logic          spi_miso_i,
    output logic               flag_output_ten_n_o,
    // Second level memory write port
    output rbl_pkg::rbl_l2_wr_s l2_wr_o,
    input  wire logic          l2_ready_i,
    // Core launch
    output logic               core_run_o,
    output logic [31:0]        core_pc_o,
    output logic               ext_pack16_o,
    output logic               boot_error_o
);
    import rbl_pkg::*;

    rbl_state_e state_q;
    logic [2:0]  mode_q;
    logic [4:0]  wait_q;
    logic [2:0]  hdr_q;
    logic [31:0] left_q;
    logic [1:0]  tx_left_q;
    logic [7:0]  sh_q;
    logic [3:0]  bit_q;
    logic [7:0]  byte_q;
    logic [2:0]  div_q;
    logic        sck_q;
    logic        mosi_q;
    logic        cs_n_q;
    logic        sel_n_q;
    logic        rd_n_q;
    logic [23:0] faddr_q;
    logic        run_q;
    logic [31:0] pc_q;
    logic        pack_q;
    logic        err_q;
    rbl_l2_wr_s  l2_q;
    logic [23:0] l2_next_q;

    // Pin synchronisers
    logic [2:0]  mode_m_q;
    logic [2:0]  mode_s_q;
    logic [7:0]  fdat_m_q;
    logic [7:0]  fdat_s_q;
    logic        miso_m_q;
    logic        miso_s_q;

    logic        spi_active;
    logic        spi_tick;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic [31:0] len_next;

    function automatic rbl_state_e fetch_state(input logic [2:0] mode);
        fetch_state = (mode == `RBL_MODE_FLASH) ? ST_FL_SETUP : ST_SPI_BYTE;
    endfunction

    assign spi_active    = (state_q == ST_CMD) || (state_q == ST_SPI_BYTE);
    assign spi_tick      = spi_active && (div_q == `RBL_SPI_HALF - 3'h1);
    assign fifo_in_valid = (state_q == ST_STORE) && (hdr_q == 3'h0);
    assign fifo_out_ready = !l2_q.valid || l2_ready_i;
    assign len_next      = {byte_q, left_q[31:8]};

    always_ff @(posedge clock_i) begin
        mode_m_q <= boot_mode_code_i;
        mode_s_q <= mode_m_q;
        fdat_m_q <= flash_data_i;
        fdat_s_q <= fdat_m_q;
        miso_m_q <= spi_miso_i;
        miso_s_q <= miso_m_q;
    end

    // Serial clock enable divider
    always_ff @(posedge clock_i) begin
        if (rst_i || !spi_active || spi_tick) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q   <= ST_SETTLE;
            mode_q    <= 3'h0;
            wait_q    <= `RBL_SETTLE;
            hdr_q     <= 3'h0;
            left_q    <= 32'h0000_0000;
            tx_left_q <= 2'h0;
            sh_q      <= 8'h00;
            bit_q     <= 4'h0;
            byte_q    <= 8'h00;
            sck_q     <= 1'b0;
            mosi_q    <= 1'b0;
            cs_n_q    <= 1'b1;
            sel_n_q   <= 1'b1;
            rd_n_q    <= 1'b1;
            faddr_q   <= 24'h00_0000;
            run_q     <= 1'b0;
            pc_q      <= 32'h0000_0000;
            pack_q    <= 1'b0;
            err_q     <= 1'b0;
        end else if (sw_reset_i) begin
            cs_n_q  <= 1'b1;
            sel_n_q <= 1'b1;
            rd_n_q  <= 1'b1;
            sck_q   <= 1'b0;
            mosi_q  <= 1'b0;
            pack_q  <= 1'b0;
            err_q   <= 1'b0;
            faddr_q <= 24'h00_0000;
            if (bypass_boot_i) begin
                run_q   <= 1'b1;
                pc_q    <= `RBL_L2_BASE;
                state_q <= ST_RUN;
            end else begin
                run_q   <= 1'b0;
                wait_q  <= `RBL_SETTLE;
                state_q <= ST_SETTLE;
            end
        end else begin
            case (state_q)
                ST_SETTLE: begin
                    if (wait_q == 5'h00) begin
                        mode_q  <= mode_s_q;
                        state_q <= ST_DISPATCH;
                    end else begin
                        wait_q <= wait_q - 5'h01;
                    end
                end
                ST_DISPATCH: begin
                    hdr_q <= `RBL_LEN_BYTES;
                    case (mode_q)
                        `RBL_MODE_EXT: begin
                            pc_q    <= `RBL_EXT_START;
                            pack_q  <= 1'b1;
                            run_q   <= 1'b1;
                            state_q <= ST_RUN;
                        end
                        `RBL_MODE_FLASH: begin
                            wait_q  <= `RBL_FL_SETUP - 5'h01;
                            sel_n_q <= 1'b0;
                            state_q <= ST_FL_SETUP;
                        end
                        `RBL_MODE_SPI8, `RBL_MODE_SPI16: begin
                            cs_n_q    <= 1'b0;
                            sh_q      <= `RBL_SPI_READ_CMD;
                            mosi_q    <= 1'(`RBL_SPI_READ_CMD >> 7);
                            bit_q     <= 4'h0;
                            tx_left_q <= (mode_q == `RBL_MODE_SPI8) ? 2'h1 : 2'h2;
                            state_q   <= ST_CMD;
                        end
                        default: begin
                            err_q   <= 1'b1;
                            state_q <= ST_ERROR;
                        end
                    endcase
                end
                ST_CMD, ST_SPI_BYTE: begin
                    if (spi_tick && !sck_q) begin
                        sck_q <= 1'b1;
                        sh_q  <= {sh_q[6:0], miso_s_q};
                        bit_q <= bit_q + 4'h1;
                    end else if (spi_tick) begin
                        sck_q <= 1'b0;
                        if (bit_q != 4'h8) begin
                            mosi_q <= sh_q[7];
                        end else begin
                            bit_q <= 4'h0;
                            if (state_q == ST_SPI_BYTE) begin
                                byte_q  <= sh_q;
                                state_q <= ST_STORE;
                            end else if (tx_left_q == 2'h0) begin
                                sh_q    <= 8'h00;
                                mosi_q  <= 1'b0;
                                state_q <= ST_SPI_BYTE;
                            end else begin
                                tx_left_q <= tx_left_q - 2'h1;
                                if (tx_left_q == 2'h2) begin
                                    sh_q   <= 8'(`RBL_SPI_ADDR >> 8);
                                    mosi_q <= 1'(`RBL_SPI_ADDR >> 15);
                                end else begin
                                    sh_q   <= 8'(`RBL_SPI_ADDR);
                                    mosi_q <= 1'(`RBL_SPI_ADDR >> 7);
                                end
                            end
                        end
                    end
                end
                ST_FL_SETUP: begin
                    if (wait_q == 5'h00) begin
                        rd_n_q  <= 1'b0;
                        wait_q  <= `RBL_FL_ACCESS - 5'h01;
                        state_q <= ST_FL_ACCESS;
                    end else begin
                        wait_q <= wait_q - 5'h01;
                    end
                end
                ST_FL_ACCESS: begin
                    if (wait_q == 5'h00) begin
                        byte_q  <= fdat_s_q;
                        rd_n_q  <= 1'b1;
                        wait_q  <= `RBL_FL_HOLD - 5'h01;
                        state_q <= ST_FL_HOLD;
                    end else begin
                        wait_q <= wait_q - 5'h01;
                    end
                end
                ST_FL_HOLD: begin
                    if (wait_q == 5'h00) begin
                        sel_n_q <= 1'b1;
                        faddr_q <= faddr_q + 24'h00_0001;
                        state_q <= ST_STORE;
                    end else begin
                        wait_q <= wait_q - 5'h01;
                    end
                end
                ST_STORE: begin
                    sh_q <= 8'h00;
                    if (hdr_q != 3'h0) begin
                        left_q <= len_next;
                        hdr_q  <= hdr_q - 3'h1;
                        if (hdr_q == 3'h1 && len_next == 32'h0000_0000) begin
                            state_q <= ST_DRAIN;
                        end else begin
                            state_q <= fetch_state(mode_q);
                        end
                    end else if (fifo_in_ready) begin
                        left_q <= left_q - 32'h0000_0001;
                        if (left_q == 32'h0000_0001) begin
                            state_q <= ST_DRAIN;
                        end else begin
                            state_q <= fetch_state(mode_q);
                        end
                    end
                    if (state_q == ST_STORE && mode_q == `RBL_MODE_FLASH) begin
                        wait_q  <= `RBL_FL_SETUP - 5'h01;
                        sel_n_q <= (hdr_q == 3'h0 && !fifo_in_ready) ||
                                   (hdr_q == 3'h1 && len_next == 32'h0000_0000) ||
                                   (hdr_q == 3'h0 && left_q == 32'h0000_0001);
                    end
                end
                ST_DRAIN: begin
                    cs_n_q <= 1'b1;
                    if (!fifo_out_valid && !l2_q.valid) begin
                        pc_q    <= `RBL_L2_BASE;
                        run_q   <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN, ST_ERROR: begin
                    state_q <= state_q;
                end
                default: begin
                    state_q <= ST_ERROR;
                end
            endcase
        end
    end

    // Memory write stage
    always_ff @(posedge clock_i) begin
        if (rst_i || sw_reset_i) begin
            l2_q      <= '0;
            l2_next_q <= 24'(`RBL_L2_BASE);
        end else if (fifo_out_ready) begin
            l2_q.valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                l2_q.addr <= l2_next_q;
                l2_q.data <= fifo_out_data;
                l2_next_q <= l2_next_q + 24'h00_0001;
            end
        end
    end

    rbl_fifo #(
        .WIDTH (8),
        .DEPTH (`RBL_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .flush_i     (sw_reset_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (byte_q),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign bank0_sel_n_o       = sel_n_q;
    assign flash_rd_n_o        = rd_n_q;
    assign flash_addr_o        = faddr_q;
    assign spi_sck_o           = sck_q;
    assign spi_mosi_o          = mosi_q;
    assign flag_output_ten_n_o = cs_n_q;
    assign l2_wr_o             = l2_q;
    assign core_run_o          = run_q;
    assign core_pc_o           = pc_q;
    assign ext_pack16_o        = pack_q;
    assign boot_error_o        = err_q;

endmodule

`default_nettype wire

// file: tb/rbl_loader_assertions.sv
// Purpose: Port-level checks of the boot loader
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to rbl_loader below
`timescale 1ns/1ps
`default_nettype none

module rbl_loader_checker
    import rbl_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       sw_reset_i,
    input  wire logic       bypass_boot_i,
    // Boot memory pins
    input  wire logic       bank0_sel_n_o,
    input  wire logic       flash_rd_n_o,
    input  wire logic       spi_sck_o,
    input  wire logic       flag_output_ten_n_o,
    // Memory write and launch
    input  wire rbl_l2_wr_s l2_wr_o,
    input  wire logic       l2_ready_i,
    input  wire logic       core_run_o,
    input  wire logic [31:0] core_pc_o,
    input  wire logic       ext_pack16_o,
    input  wire logic       boot_error_o
);
    logic [4:0]  lo_cnt_q;
    logic [23:0] nxt_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clock_i) begin
        if (rst_i || flash_rd_n_o) begin
            lo_cnt_q <= 5'h00;
        end else begin
            lo_cnt_q <= lo_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || sw_reset_i) begin
            nxt_q <= 24'h000000;
        end else if (l2_wr_o.valid && l2_ready_i) begin
            nxt_q <= l2_wr_o.addr + 24'h000001;
        end
    end

    sequence s_setup;
        flash_rd_n_o [*4] ##1 !flash_rd_n_o;
    endsequence
    sequence s_hold;
        !bank0_sel_n_o [*3] ##1 bank0_sel_n_o;
    endsequence

    a_flash_setup_len: assert property ($fell(bank0_sel_n_o) |-> s_setup)
        else $error("flash setup not four cycles");
    a_flash_access_len: assert property (
        $rose(flash_rd_n_o) && !$past(sw_reset_i) |-> lo_cnt_q == 5'h0F)
        else $error("flash access not fifteen cycles");
    a_flash_hold_len: assert property (
        $rose(flash_rd_n_o) && !$past(sw_reset_i) |-> s_hold)
        else $error("flash hold not three cycles");
    a_ext_start_pc: assert property (
        core_run_o && ext_pack16_o |-> core_pc_o == 32'h0200_0000)
        else $error("external start address wrong");
    a_reserved_no_run: assert property (boot_error_o |-> !core_run_o)
        else $error("run with reserved code");
    a_no_early_run: assert property (
        !bank0_sel_n_o || !flag_output_ten_n_o || l2_wr_o.valid |-> !core_run_o)
        else $error("run while loading");
    a_write_held_stall: assert property (
        l2_wr_o.valid && !l2_ready_i && !sw_reset_i |=> $stable(l2_wr_o))
        else $error("write changed while stalled");
    a_write_addr_order: assert property (l2_wr_o.valid |-> l2_wr_o.addr == nxt_q)
        else $error("write address out of order");
    a_bypass_jump_now: assert property (
        sw_reset_i && bypass_boot_i |=> core_run_o && core_pc_o == 32'h0000_0000)
        else $error("bypass did not jump");
    a_launch_pc_base: assert property (
        $rose(core_run_o) && !ext_pack16_o |-> core_pc_o == 32'h0000_0000)
        else $error("launch address wrong");
    a_sck_idle_low: assert property (flag_output_ten_n_o |-> !spi_sck_o)
        else $error("serial clock moved while deselected");
endmodule

bind rbl_loader rbl_loader_checker rbl_loader_checker_i (
    .clock_i(clock_i), .rst_i(rst_i), .sw_reset_i(sw_reset_i),
    .bypass_boot_i(bypass_boot_i), .bank0_sel_n_o(bank0_sel_n_o),
    .flash_rd_n_o(flash_rd_n_o), .spi_sck_o(spi_sck_o),
    .flag_output_ten_n_o(flag_output_ten_n_o), .l2_wr_o(l2_wr_o),
    .l2_ready_i(l2_ready_i), .core_run_o(core_run_o), .core_pc_o(core_pc_o),
    .ext_pack16_o(ext_pack16_o), .boot_error_o(boot_error_o)
);
`default_nettype wire

// file: tb/rbl_boot_mem_model.sv
// Purpose: Behavioural boot flash and serial memory
// Assumes: Image is a little-endian count then payload
// Notes:   Released flash lines show the inverse of the addressed byte, released miso the inverse of its last value
`timescale 1ns/1ps
`default_nettype none

module rbl_boot_mem_model (
    // Image setup
    input  wire logic        spi16_i,
    input  wire logic [31:0] len_i,
    // Parallel flash
    input  wire logic        bank0_sel_n_i,
    input  wire logic        flash_rd_n_i,
    input  wire logic [23:0] flash_addr_i,
    output logic      [7:0]  flash_data_o,
    // Serial memory
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic      [23:0] hdr_o
);
    int n_rise = 0;
    int hb;
    logic miso_q = 1'b0;

    function automatic logic [7:0] img(input logic [31:0] a);
        img = (a < 4) ? 8'(len_i >> (8 * a)) : (8'(a - 4) ^ 8'hC3);
    endfunction

    assign flash_data_o = (!bank0_sel_n_i && !flash_rd_n_i) ?
        img(32'(flash_addr_i)) : ~img(32'(flash_addr_i));

    assign hb = spi16_i ? 24 : 16;
    assign miso_o = miso_q;

    initial hdr_o = 24'h000000;

    always @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            n_rise <= 0;
        end else begin
            n_rise <= n_rise + 1;
            // Header kept after deselect, cleared on first bit of a frame
            if (n_rise == 0) hdr_o <= {23'h000000, mosi_i};
            else if (n_rise < hb) hdr_o <= {hdr_o[22:0], mosi_i};
        end
    end

    always @(negedge sck_i or posedge cs_n_i) begin
        logic [7:0] b;
        int k;
        k = n_rise - hb;
        b = img(32'(k / 8));
        if (cs_n_i) miso_q <= ~miso_q;
        else if (k >= 0) miso_q <= b[7 - k % 8];
    end
endmodule
`default_nettype wire

// file: tb/rbl_loader_test.sv
// Purpose: Self-checking bench of the boot loader
// Assumes: Inputs change on the falling clock edge
// Notes:   Writes are captured by a monitor into mem_q
`timescale 1ns/1ps
`default_nettype none

module rbl_loader_test;
    import rbl_pkg::*;

    logic clock_i = 1'b0, rst_i = 1'b1, sw_reset = 1'b0, bypass = 1'b0;
    logic [2:0] mode = 3'h0;
    logic ready = 1'b1, sel_n, rd_n, sck, mosi, miso, cs_n, run, pack, err;
    logic [23:0] faddr, hdr;
    logic [7:0] fdata;
    logic [31:0] pc, len = 32'h0;
    logic [7:0] mem_q [0:15];
    rbl_l2_wr_s l2;
    int n_mismatch = 0, n_tests = 0, n_wr = 0;

    always #5 clock_i = ~clock_i;

    rbl_loader rbl_loader_i (.clock_i(clock_i), .rst_i(rst_i), .sw_reset_i(sw_reset),
        .bypass_boot_i(bypass), .boot_mode_code_i(mode), .bank0_sel_n_o(sel_n),
        .flash_rd_n_o(rd_n), .flash_addr_o(faddr), .flash_data_i(fdata),
        .spi_sck_o(sck), .spi_mosi_o(mosi), .spi_miso_i(miso),
        .flag_output_ten_n_o(cs_n), .l2_wr_o(l2), .l2_ready_i(ready),
        .core_run_o(run), .core_pc_o(pc), .ext_pack16_o(pack), .boot_error_o(err));

    rbl_boot_mem_model rbl_boot_mem_model_i (.spi16_i(mode[0]), .len_i(len),
        .bank0_sel_n_i(sel_n), .flash_rd_n_i(rd_n), .flash_addr_i(faddr),
        .flash_data_o(fdata), .cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi),
        .miso_o(miso), .hdr_o(hdr));

    always @(posedge clock_i) begin
        if (!rst_i && l2.valid === 1'b1 && ready) begin
            mem_q[l2.addr[3:0]] = l2.data;
            n_wr++;
        end
    end

    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(negedge clock_i);
        mode = m;
        rst_i = 1'b1;
        repeat (8) @(negedge clock_i);
        n_wr = 0;
        rst_i = 1'b0;
    endtask

    task automatic wait_run(input int lim);
        int k;
        k = 0;
        while (run !== 1'b1 && err !== 1'b1 && k < lim) begin
            @(negedge clock_i);
            k++;
        end
    endtask

    task automatic t_ext;
        do_reset(3'h0);
        wait_run(50);
        chk_word("run", 1, run);
        chk_word("pc", 32'h0200_0000, pc);
        chk_word("pack", 1, pack);
        chk_word("writes", 0, n_wr);
    endtask

    task automatic t_reserved;
        for (int m = 4; m < 8; m++) begin
            do_reset(3'(m));
            repeat (20) @(negedge clock_i);
            chk_word("error", 1, err);
            chk_word("run", 0, run);
        end
    endtask

    task automatic t_load(input logic [2:0] m, input logic [31:0] n, input logic stall);
        len = n;
        ready = ~stall;
        do_reset(m);
        if (stall) begin
            repeat (300) @(negedge clock_i);
            ready = 1'b1;
        end
        wait_run(20000);
        chk_word("run", 1, run);
        chk_word("pc", 0, pc);
        chk_word("writes", n, n_wr);
        for (int i = 0; i < n; i++) chk_word("data", 8'(i) ^ 8'hC3, mem_q[i]);
        if (m[1]) chk_word("header", m[0] ? 24'h030000 : 24'h000300, hdr);
    endtask

    task automatic pulse_sw(input logic byp);
        bypass = byp;
        @(negedge clock_i);
        sw_reset = 1'b1;
        @(negedge clock_i);
        sw_reset = 1'b0;
    endtask

    task automatic t_sw_reset;
        mode = 3'h0;
        repeat (4) @(negedge clock_i);
        pulse_sw(1'b0);
        chk_word("run", 0, run);
        wait_run(50);
        chk_word("pc", 32'h0200_0000, pc);
        chk_word("pack", 1, pack);
        mode = 3'h5;
        repeat (4) @(negedge clock_i);
        pulse_sw(1'b1);
        chk_word("run", 1, run);
        chk_word("pc", 0, pc);
        repeat (8) @(negedge clock_i);
        chk_word("error", 0, err);
        chk_word("run", 1, run);
    endtask

    initial begin
        t_ext();
        t_reserved();
        t_load(3'h1, 32'd8, 1'b1);
        t_load(3'h2, 32'd5, 1'b0);
        t_load(3'h3, 32'd0, 1'b0);
        t_sw_reset();
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
